/* src/port_host_pkg.sv */
/*
 * shared constants and types for the host that drives one port of a
 * two-port shared memory with conflict, mailbox and token-latch logic.
 * assumes a 20 MHz clock; all pin timing is counted in whole cycles.
 */
package port_host_pkg;

   // ----------------------------------------------------------------
   // clock and pin timing
   // ----------------------------------------------------------------
   localparam int CLK_NS        = 50;  // clock period
   localparam int ARB_NS        = 45;  // conflict decision after address/select
   localparam int PULSE_NS      = 50;  // write strobe width, least
   localparam int ACCESS_NS     = 55;  // read data valid after enable
   localparam int HOLD_NS       = 25;  // write hold after conflict release
   localparam int ARB_CYC    = (ARB_NS + CLK_NS - 1) / CLK_NS;     // round up
   localparam int PULSE_CYC  = (PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_CYC   = (HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int TMR_W      = 4;                                  // phase timer width

   // ----------------------------------------------------------------
   // address map of the device outside
   // ----------------------------------------------------------------
   localparam int          IDX_W        = 15;        // word index width
   localparam logic [14:0] MAIL_LEFT    = 15'h7FFE;  // box that flags the left side
   localparam logic [14:0] MAIL_RIGHT   = 15'h7FFF;  // box that flags the right side
   localparam int          FLAG_IDX_W   = 3;         // token latch index width
   localparam logic [7:0]  FLAG_HELD    = 8'h00;     // token held by this side
   localparam logic [7:0]  FLAG_CLAIM   = 8'h00;     // write zero: request
   localparam logic [7:0]  FLAG_FREE    = 8'h01;     // write one: release

   // ----------------------------------------------------------------
   // user commands and sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_READ      = 3'h0,
      OP_WRITE     = 3'h1,
      OP_SEM_CLAIM = 3'h2,
      OP_SEM_FREE  = 3'h3,
      OP_SEM_READ  = 3'h4,
      OP_MAIL_POST = 3'h5,
      OP_MAIL_READ = 3'h6
   } op_t;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_SETUP  = 3'h1,
      ST_STROBE = 3'h2,
      ST_HOLD   = 3'h3,
      ST_REST   = 3'h4
   } state_t;

endpackage : port_host_pkg

/* src/phase_timer.sv */
/*
 * down counter that times each phase of a port access.
 * assumes load is pulsed on the cycle a phase is entered.
 */
`timescale 1ns/1ps
`default_nettype none
module phase_timer #(
   parameter int W = 4
) (
   input  wire logic         clock_in,   // system clock
   input  wire logic         rst_b_in,   // sync reset, active low
   input  wire logic         load_in,    // start a new phase
   input  wire logic [W-1:0] count_in,   // phase length minus one
   output logic              expired_out // phase is in its last cycle
);
   initial begin
      if (W < 2) $error("phase_timer width too small");
   end

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   logic [W-1:0] cnt_q;  // cycles left in the phase after this one
   logic [W-1:0] cnt_d;  // next value

   // load wins over counting so back to back phases keep their length
   always_comb begin
      cnt_d = cnt_q;
      if (load_in) begin
         cnt_d = count_in;
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - W'(1);
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign expired_out = (cnt_q == '0);
endmodule : phase_timer
`default_nettype wire

/* src/port_host.sv */
/*
 * host controller for one port of a two-port shared memory: plain word
 * reads and writes, mailbox post and fetch, token-latch claim/free/read.
 * assumes the device pins are synchronous to clock_in and the data bus
 * is resolved outside from data_out/data_oe_n_out.
 */
// How it works
// RULE_01: device compares addresses; conflict only on match
// RULE_02: earlier-settled port wins; later port sees conflict
// RULE_03: master decision ignores read or write
// RULE_04: conflicted port's write is internally gated
// RULE_05: role select picks output or input conflict pins
// RULE_06: master ignores writes while driving conflict low
// RULE_07: slave only inhibits writes from conflict input
// RULE_08: hold slave conflict high; low blocks writes
// RULE_09: address and select settle before write strobe
// RULE_10: only one master when widening the word
// RULE_11: AND all conflict outputs when stacking depth
// RULE_12: right write to 7FFE flags left side
// RULE_13: left read-enable at 7FFE clears left flag
// RULE_14: left write 7FFF flags right; right read clears
// RULE_15: mailbox words stay ordinary storage
// RULE_16: eight latches, bit zero written, reads replicated
// RULE_17: token space: memory deselected, token select low
// RULE_18: zero into free latch grants the token
// RULE_19: zero while other holds becomes pending request
// RULE_20: release with pending request hands token over
// RULE_21: release without request frees the latch
// RULE_22: latch read value held until select/enable drop
// RULE_23: ports act independently, no device clock
`timescale 1ns/1ps
`default_nettype none
module port_host #(
   parameter int         DW          = 8,     // data width
   parameter int         DEPTH_N     = 1,     // devices stacked in depth
   parameter logic       LEFT_SIDE   = 1'b1,  // this host owns the left port
   parameter logic       ROLE_MASTER = 1'b1   // strap for this device's role
) (
   input  wire logic                clock_in,          // 20 MHz clock
   input  wire logic                rst_b_in,          // sync reset, active low
   input  wire logic                cmd_valid_in,      // start a command
   input  wire port_host_pkg::op_t  cmd_op_in,         // command code
   input  wire logic [14:0]         cmd_addr_in,       // word index or latch index
   input  wire logic [DW-1:0]       cmd_wdata_in,      // write data
   input  wire logic                block_writes_in,   // hold slave inhibit low
   output logic                     cmd_ready_out,     // idle, may take a command
   output logic                     done_out,          // one-cycle completion
   output logic [DW-1:0]            rdata_out,         // read result
   output logic                     granted_out,       // token held after claim/read
   output logic                     collided_out,      // last memory write had to wait
   output logic                     mail_pending_out,  // our mail flag is set
   output logic [14:0]              word_index_out,    // address pins
   output logic                     mem_select_n_out,  // memory select, low active
   output logic                     flag_space_select_n_out, // token select, low
   output logic                     rw_n_out,          // low writes
   output logic                     out_enable_n_out,  // low enables read data
   input  wire logic [DW-1:0]       data_in,           // data pins, sampled
   output logic [DW-1:0]            data_out,          // data pins, driven
   output logic                     data_oe_n_out,     // low while we drive data
   input  wire logic [DEPTH_N-1:0]  conflict_n_in,     // conflict outputs, low active
   input  wire logic                mail_flag_n_in,    // our mail flag, low active
   output logic                     role_master_out,   // role strap to device
   output logic                     write_block_n_out  // slave conflict input drive
);
   initial begin
      if (DW != 8) $error("port_host supports an 8-bit data path only");
      if (DEPTH_N < 1) $error("port_host needs at least one device");
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      port_host_pkg::state_t st;        // sequencer state
      port_host_pkg::op_t    op;        // command in flight
      logic                  wr;        // current phase writes
      logic                  sem_rd;    // claim is in its read-back phase
      logic [14:0]           idx;       // address pins
      logic                  mem_n;     // memory select
      logic                  sem_n;     // token select
      logic                  rw_n;      // write strobe
      logic                  oe_n;      // read enable
      logic [DW-1:0]         dout;      // data driven
      logic                  doe_n;     // data drive enable
      logic [DW-1:0]         rdata;     // captured read data
      logic                  done;      // completion pulse
      logic                  granted;   // token result
      logic                  collided;  // write waited on conflict
      logic                  mail;      // mail pending
      logic                  role;      // role strap
      logic                  blk_n;     // slave inhibit drive
      logic                  rdy;       // idle
   } host_state_t;

   host_state_t s_q;  // registered state
   host_state_t s_d;  // next state

   logic                              tmr_load;     // start a phase
   logic [port_host_pkg::TMR_W-1:0]   tmr_count;    // phase length minus one
   logic                              tmr_expired;  // phase in its last cycle
   logic                              clear_path;   // every stacked device clear

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // phase length in cycles to timer load value
   function automatic logic [port_host_pkg::TMR_W-1:0] span(input int cyc);
      span = port_host_pkg::TMR_W'((cyc < 1 ? 1 : cyc) - 1);
   endfunction : span

   // command touches the token space rather than memory
   function automatic logic is_sem(input port_host_pkg::op_t op);
      is_sem = (op == port_host_pkg::OP_SEM_CLAIM) || (op == port_host_pkg::OP_SEM_FREE) ||
               (op == port_host_pkg::OP_SEM_READ);
   endfunction : is_sem

   // combined conflict of a depth-stacked array
   assign clear_path = &conflict_n_in;  // RULE_11

   phase_timer #(
      .W (port_host_pkg::TMR_W)
   ) u_timer (
      .clock_in    (clock_in),
      .rst_b_in    (rst_b_in),
      .load_in     (tmr_load),
      .count_in    (tmr_count),
      .expired_out (tmr_expired)
   );

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   // pins are derived from the next state so every pin leaves a flop
   always_comb begin
      s_d       = s_q;
      tmr_load  = 1'b0;
      tmr_count = '0;
      s_d.done  = 1'b0;
      s_d.mail  = ~mail_flag_n_in;
      s_d.role  = ROLE_MASTER;         // RULE_10
      s_d.blk_n = ~block_writes_in;    // RULE_08
      case (s_q.st)
         port_host_pkg::ST_IDLE: begin
            if (cmd_valid_in) begin
               s_d.op     = cmd_op_in;
               s_d.sem_rd = 1'b0;
               s_d.wr     = (cmd_op_in == port_host_pkg::OP_WRITE) ||
                            (cmd_op_in == port_host_pkg::OP_MAIL_POST) ||
                            (cmd_op_in == port_host_pkg::OP_SEM_CLAIM) ||
                            (cmd_op_in == port_host_pkg::OP_SEM_FREE);
               // token latches answer to the low index bits only
               s_d.idx    = cmd_addr_in;
               s_d.dout   = cmd_wdata_in;
               if (is_sem(cmd_op_in)) begin
                  s_d.idx = {12'h000, cmd_addr_in[port_host_pkg::FLAG_IDX_W-1:0]}; // RULE_16
               end
               // a claim writes zero, a free writes one, on bit zero
               if (cmd_op_in == port_host_pkg::OP_SEM_CLAIM) begin
                  s_d.dout = port_host_pkg::FLAG_CLAIM;  // RULE_18
               end
               if (cmd_op_in == port_host_pkg::OP_SEM_FREE) begin
                  s_d.dout = port_host_pkg::FLAG_FREE;   // RULE_20
               end
               // post into the partner's box, fetch from our own
               if (cmd_op_in == port_host_pkg::OP_MAIL_POST) begin
                  s_d.idx = LEFT_SIDE ? port_host_pkg::MAIL_RIGHT
                                      : port_host_pkg::MAIL_LEFT;  // RULE_14
               end
               if (cmd_op_in == port_host_pkg::OP_MAIL_READ) begin
                  s_d.idx = LEFT_SIDE ? port_host_pkg::MAIL_LEFT
                                      : port_host_pkg::MAIL_RIGHT; // RULE_13
               end
               s_d.st    = port_host_pkg::ST_SETUP;
               tmr_load  = 1'b1;
               tmr_count = span(port_host_pkg::ARB_CYC);
            end
         end
         port_host_pkg::ST_SETUP: begin
            // wait out the decision; a write that lost keeps waiting
            if (tmr_expired) begin
               if (s_q.wr && !is_sem(s_q.op) && !clear_path) begin
                  s_d.collided = 1'b1;                   // RULE_02
                  tmr_load     = 1'b1;
                  tmr_count    = span(port_host_pkg::HOLD_CYC);
               end else begin
                  s_d.st    = port_host_pkg::ST_STROBE;  // RULE_09
                  tmr_load  = 1'b1;
                  tmr_count = s_q.wr ? span(port_host_pkg::PULSE_CYC)
                                     : span(port_host_pkg::ACCESS_CYC);
               end
            end
         end
         port_host_pkg::ST_STROBE: begin
            if (tmr_expired) begin
               if (!s_q.wr) begin
                  s_d.rdata = data_in;
                  // a held token reads as zero on every bit
                  if (is_sem(s_q.op)) begin
                     s_d.granted = (data_in == port_host_pkg::FLAG_HELD);  // RULE_16
                  end
               end else if (s_q.op == port_host_pkg::OP_SEM_FREE) begin
                  s_d.granted = 1'b0;                    // RULE_21
               end
               s_d.st = port_host_pkg::ST_HOLD;
            end
         end
         port_host_pkg::ST_HOLD: begin
            s_d.st = port_host_pkg::ST_REST;
         end
         port_host_pkg::ST_REST: begin
            // every access ends deselected, so a token read never sticks
            if (s_q.op == port_host_pkg::OP_SEM_CLAIM && !s_q.sem_rd) begin
               s_d.sem_rd = 1'b1;                       // RULE_22
               s_d.wr     = 1'b0;
               s_d.st     = port_host_pkg::ST_SETUP;
               tmr_load   = 1'b1;
               tmr_count  = span(port_host_pkg::ARB_CYC);
            end else begin
               s_d.st   = port_host_pkg::ST_IDLE;
               s_d.done = 1'b1;
            end
         end
         default: begin
            s_d.st = port_host_pkg::ST_IDLE;
         end
      endcase
      if (s_d.st == port_host_pkg::ST_SETUP && s_q.st == port_host_pkg::ST_IDLE &&
          s_d.wr && !is_sem(s_d.op)) begin
         s_d.collided = 1'b0;
      end
      s_d.rdy   = (s_d.st == port_host_pkg::ST_IDLE);
      // pin pattern of the next phase
      s_d.mem_n = 1'b1;
      s_d.sem_n = 1'b1;
      s_d.rw_n  = 1'b1;
      s_d.oe_n  = 1'b1;
      s_d.doe_n = 1'b1;
      if (s_d.st == port_host_pkg::ST_SETUP || s_d.st == port_host_pkg::ST_STROBE ||
          s_d.st == port_host_pkg::ST_HOLD) begin
         s_d.sem_n = ~is_sem(s_d.op);                   // RULE_17
         s_d.mem_n = is_sem(s_d.op);                    // RULE_17
         s_d.doe_n = ~s_d.wr;
      end
      if (s_d.st == port_host_pkg::ST_STROBE) begin
         s_d.rw_n = ~s_d.wr;                            // RULE_04
         s_d.oe_n = s_d.wr;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         s_q       <= '0;
         s_q.rdy   <= 1'b1;
         s_q.mem_n <= 1'b1;
         s_q.sem_n <= 1'b1;
         s_q.rw_n  <= 1'b1;
         s_q.oe_n  <= 1'b1;
         s_q.doe_n <= 1'b1;
         s_q.role  <= ROLE_MASTER;
         s_q.blk_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign cmd_ready_out           = s_q.rdy;
   assign done_out                = s_q.done;
   assign rdata_out               = s_q.rdata;
   assign granted_out             = s_q.granted;
   assign collided_out            = s_q.collided;
   assign mail_pending_out        = s_q.mail;
   assign word_index_out          = s_q.idx;
   assign mem_select_n_out        = s_q.mem_n;
   assign flag_space_select_n_out = s_q.sem_n;
   assign rw_n_out                = s_q.rw_n;
   assign out_enable_n_out        = s_q.oe_n;
   assign data_out                = s_q.dout;
   assign data_oe_n_out           = s_q.doe_n;
   assign role_master_out         = s_q.role;
   assign write_block_n_out       = s_q.blk_n;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);

   sequence write_phase;
      !rw_n_out && !flag_space_select_n_out;
   endsequence
   sequence read_back;
      !out_enable_n_out && !flag_space_select_n_out;
   endsequence

   a_one_space_only: assert property (!(!mem_select_n_out && !flag_space_select_n_out)) // RULE_17
      else $error("memory and token space selected together");
   a_strobe_after_setup: assert property ($fell(rw_n_out) |->             // RULE_09
      $past(!mem_select_n_out || !flag_space_select_n_out) && $stable(word_index_out))
      else $error("write strobe without settled address and select");
   a_stall_on_conflict: assert property (                                 // RULE_11
      (s_q.st == port_host_pkg::ST_SETUP && s_q.wr && !is_sem(s_q.op) && tmr_expired &&
       !clear_path) |=> (s_q.st == port_host_pkg::ST_SETUP) && rw_n_out && collided_out)
      else $error("write went ahead during a conflict");
   a_block_follows: assert property (block_writes_in |=> !write_block_n_out) // RULE_08
      else $error("slave inhibit not driven low");
   a_role_steady: assert property (##1 $stable(role_master_out))           // RULE_10
      else $error("role strap changed");
   a_claim_reads_back: assert property (write_phase and                     // RULE_22
      ##0 (s_q.op == port_host_pkg::OP_SEM_CLAIM) |->
      ##[1:12] flag_space_select_n_out ##[1:12] read_back)
      else $error("claim not followed by a fresh read");
   a_done_deselected: assert property (done_out |-> mem_select_n_out &&     // RULE_22
      flag_space_select_n_out && rw_n_out && out_enable_n_out && data_oe_n_out)
      else $error("access finished with the port still selected");
endmodule : port_host
`default_nettype wire

/* tb/dev_model.sv */
/* device model on the far side of one left-port host: word store, mail
   flags, eight token latches, conflict pin. assumes host pins change on
   clock edges; the right port acts through tasks called by the bench. */
`timescale 1ns/1ps
`default_nettype none
module dev_model (
   input  wire logic        clock_in,       // bench clock
   input  wire logic [14:0] idx_in,         // left word index
   input  wire logic        sel_n_in,       // left memory select
   input  wire logic        sem_n_in,       // left token select
   input  wire logic        rw_n_in,        // left write strobe
   input  wire logic        oe_n_in,        // left output enable
   input  wire logic [7:0]  wdata_in,       // data driven by host
   input  wire logic        master_in,      // role strap
   input  wire logic        block_n_in,     // slave inhibit input
   output logic      [7:0]  rdata_out,      // data seen by host
   output logic             conflict_n_out, // left conflict pin
   output logic             flag_n_out      // left mail flag
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0]  mem [0:32767];        // word store
   int          owner [8];            // 0 free, 1 left, 2 right
   bit          req [3][8];           // pending request per side
   logic        flag_l_n = 1'b1;      // left mail flag
   logic        flag_r_n = 1'b1;      // right mail flag
   logic        r_hold   = 1'b0;      // right port parked first
   logic [14:0] r_addr   = 15'h0000;  // right parked address
   logic [7:0]  last_q   = 8'h00;     // last value on data pins
   logic [7:0]  sem_q    = 8'h00;     // latched token read
   logic        sem_rd_q = 1'b0;      // token read in progress
   wire l_mem = !sel_n_in && sem_n_in;
   wire l_sem = sel_n_in && !sem_n_in;
   wire busy = master_in && r_hold && l_mem && idx_in == r_addr;
   wire wr_ok = master_in ? !busy : block_n_in;
   wire [7:0] tok = {8{owner[idx_in[2:0]] != 1}};
   assign conflict_n_out = master_in ? !busy : 1'b1;
   assign flag_n_out = flag_l_n;
   // released pins show the inverse of the last value, never a stale copy
   assign rdata_out = (oe_n_in || !(l_mem || l_sem)) ? ~last_q :
                      l_sem ? (sem_rd_q ? sem_q : tok) : mem[idx_in];
   // left port actions, seen on the edge where the host holds them
   always @(posedge clock_in) begin
      last_q <= rdata_out;
      sem_rd_q <= l_sem && !oe_n_in;
      if (l_sem && !oe_n_in && !sem_rd_q) sem_q <= tok;
      if (l_mem && !oe_n_in && idx_in == 15'h7FFE) flag_l_n = 1'b1;
      if (l_mem && !rw_n_in && wr_ok) begin
         mem[idx_in] = wdata_in;
         if (idx_in == 15'h7FFF) flag_r_n = 1'b0;
      end
      if (l_sem && !rw_n_in) sem_wr(1, int'(idx_in[2:0]), wdata_in[0]);
   end
   // token latch update, shared by both sides
   task automatic sem_wr(input int s, input int i, input logic b);
      if (!b && owner[i] == 0) owner[i] = s;
      else if (!b && owner[i] != s) req[s][i] = 1'b1;
      else if (b && owner[i] == s) begin
         owner[i] = req[3-s][i] ? 3 - s : 0;
         req[3-s][i] = 1'b0;
      end
      else if (b) req[s][i] = 1'b0; // request withdrawn
   endtask : sem_wr
   // right port, asynchronous to the left one
   task automatic r_write(input logic [14:0] a, input logic [7:0] d);
      mem[a] = d;
      if (a == 15'h7FFE) flag_l_n = 1'b0;
   endtask : r_write
   task automatic r_read(input logic [14:0] a, output logic [7:0] d);
      d = mem[a];
      if (a == 15'h7FFF) flag_r_n = 1'b1;
   endtask : r_read
   task automatic r_sem(input int i, input logic b);
      sem_wr(2, i, b);
   endtask : r_sem
   function automatic logic r_sem_rd(input int i);
      return owner[i] != 2;
   endfunction : r_sem_rd
endmodule : dev_model
`default_nettype wire

/* tb/testbench.sv */
/* self-checking bench for the left-port host against dev_model.
   assumes the 20 MHz clock and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic clock_in = 1'b0, rst_b_in = 1'b0, cmd_valid_in = 1'b0, blk = 1'b0;
   port_host_pkg::op_t cmd_op_in = port_host_pkg::OP_READ;
   logic [14:0] cmd_addr_in = 15'h0000, idx;
   logic [7:0] wdat = 8'h00, rdata, din, dout, rd;
   logic ready, done, granted, collided, mail_p, sel_n, sem_n, rw_n, oe_n;
   logic doe_n, master, block_n, mail_n;
   logic [0:0] conf_n;
   int num_errors = 0;
   int samples_checked = 0;
   always #25 clock_in = ~clock_in; // 50 ns period
   port_host dut_u (.clock_in(clock_in), .rst_b_in(rst_b_in), .cmd_valid_in(cmd_valid_in),
      .cmd_op_in(cmd_op_in), .cmd_addr_in(cmd_addr_in), .cmd_wdata_in(wdat),
      .block_writes_in(blk), .cmd_ready_out(ready), .done_out(done), .rdata_out(rdata),
      .granted_out(granted), .collided_out(collided), .mail_pending_out(mail_p),
      .word_index_out(idx), .mem_select_n_out(sel_n), .flag_space_select_n_out(sem_n),
      .rw_n_out(rw_n), .out_enable_n_out(oe_n), .data_in(din), .data_out(dout),
      .data_oe_n_out(doe_n), .conflict_n_in(conf_n), .mail_flag_n_in(mail_n),
      .role_master_out(master), .write_block_n_out(block_n));
   dev_model dev_u (.clock_in(clock_in), .idx_in(idx), .sel_n_in(sel_n), .sem_n_in(sem_n),
      .rw_n_in(rw_n), .oe_n_in(oe_n), .wdata_in(dout), .master_in(master),
      .block_n_in(block_n), .rdata_out(din), .conflict_n_out(conf_n[0]),
      .flag_n_out(mail_n));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_byte
   task automatic chk_bit(input logic got, input logic exp);
      chk_byte({7'h00, got}, {7'h00, exp});
   endtask : chk_bit
   task automatic wait_n(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask : wait_n
   // one command, bounded wait on the completion pulse
   task automatic cmd(input port_host_pkg::op_t op, input logic [14:0] a, input logic [7:0] d);
      int n;
      @(posedge clock_in);
      cmd_op_in <= op;
      {cmd_addr_in, wdat, cmd_valid_in} <= {a, d, 1'b1};
      @(posedge clock_in);
      cmd_valid_in <= 1'b0;
      n = 0;
      do begin
         wait_n(1);
         n++;
      end while (done !== 1'b1 && n < 200);
      chk_bit(done, 1'b1);
   endtask : cmd
   task automatic report_and_stop;
      $display("errors %0d of %0d checks", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_word_block;
      cmd(port_host_pkg::OP_WRITE, 15'h7FFE, 8'hA5);
      cmd(port_host_pkg::OP_READ, 15'h7FFE, 8'h00);
      chk_byte(rdata, 8'hA5);
      @(posedge clock_in);
      blk <= 1'b1;
      wait_n(2);
      chk_bit(block_n, 1'b0);
      @(posedge clock_in) blk <= 1'b0;
   endtask : t_word_block
   task automatic t_mail;
      dev_u.r_write(15'h7FFE, 8'h5A);
      wait_n(3);
      chk_bit(mail_p, 1'b1);
      cmd(port_host_pkg::OP_MAIL_READ, 15'h0000, 8'h00);
      chk_byte(rdata, 8'h5A);
      wait_n(3);
      chk_bit(mail_p, 1'b0);
      cmd(port_host_pkg::OP_MAIL_POST, 15'h0000, 8'hC3);
      chk_bit(dev_u.flag_r_n, 1'b0);
      dev_u.r_read(15'h7FFF, rd);
      chk_byte(rd, 8'hC3);
   endtask : t_mail
   // claim all eight, hand latch 5 to the right and back, free all
   task automatic t_sem;
      for (int i = 0; i < 8; i++) begin
         cmd(port_host_pkg::OP_SEM_CLAIM, 15'(i), 8'h00);
         chk_bit(granted, 1'b1);
      end
      dev_u.r_sem(5, 1'b0);
      chk_bit(dev_u.r_sem_rd(5), 1'b1);
      cmd(port_host_pkg::OP_SEM_FREE, 15'h0005, 8'h01);
      cmd(port_host_pkg::OP_SEM_READ, 15'h0005, 8'h00);
      chk_byte(rdata, 8'hFF);
      cmd(port_host_pkg::OP_SEM_CLAIM, 15'h0005, 8'h00);
      chk_bit(granted, 1'b0);
      dev_u.r_sem(5, 1'b1);
      cmd(port_host_pkg::OP_SEM_READ, 15'h0005, 8'h00);
      chk_byte(rdata, 8'h00);
      for (int i = 0; i < 8; i++) begin
         cmd(port_host_pkg::OP_SEM_FREE, 15'(i), 8'h01);
         chk_bit(dev_u.r_sem_rd(i), 1'b1);
      end
   endtask : t_sem
   // right port parked first on the same word: reads pass, write waits
   task automatic t_conflict;
      dev_u.r_addr = 15'h0200;
      dev_u.r_hold = 1'b1;
      cmd(port_host_pkg::OP_READ, 15'h0200, 8'h00);
      chk_byte(rdata, 8'h11);
      fork
         cmd(port_host_pkg::OP_WRITE, 15'h0200, 8'h77);
         begin
            wait_n(8);
            chk_bit(done, 1'b0);
            dev_u.r_hold = 1'b0;
         end
      join
      chk_bit(collided, 1'b1);
      chk_byte(dev_u.mem[15'h0200], 8'h77);
   endtask : t_conflict
   initial begin
      #1000000;
      num_errors++;
      report_and_stop;
   end
   initial begin
      repeat (8) @(posedge clock_in);
      rst_b_in <= 1'b1;
      wait_n(1);
      chk_bit(ready, 1'b1);
      chk_bit(master, 1'b1);
      dev_u.mem[15'h0200] = 8'h11;
      t_word_block;
      t_mail;
      t_sem;
      t_conflict;
      report_and_stop;
   end
endmodule : testbench
`default_nettype wire
